// [pkg/fru_pkg.sv]
// Constants and codes shared by both ends of the flash command link, and the header table read by the command end.
// Assumes one 125 MHz system clock on each end and an SPI mode 0 link.
// Notes on behaviour
// (RULE_01) No-operation only cancels a pending reset arm
// (RULE_02) Upper data lines ignored for reset commands
// (RULE_03) Valid software reset restores power-on defaults
// (RULE_04) Arm must directly precede reset command
// (RULE_05) Reset during program/erase aborts that operation
// (RULE_06) Fixed read-only 128-bit unique identifier
// (RULE_07) Unique-id read: opcode, four dummies, 128 bits
// (RULE_08) Table read: opcode, three address, one dummy
// (RULE_09) Chip select rise ends table read at once
// (RULE_10) Bytes 00h-03h return the signature, low first
// (RULE_11) Bytes 04h-06h: revisions and header count
// (RULE_12) Bytes 07h, 0Fh, 17h always read FFh
// (RULE_13) First header: id 00h, rev 1.0, 09h, 30h
// (RULE_14) Second header: maker id, rev 1.0, 03h, 60h
// (RULE_15) Identification read not decoded while busy
// (RULE_16) Reset commands accepted during suspend
// (RULE_17) Output MSB first, address advances per byte
// (RULE_18) Invalid arm/reset leaves state, waits command
package fru_pkg;
    // --------------------------------------------------------------
    // Opcodes
    // --------------------------------------------------------------
    localparam logic [7:0] OP_NO_OPERATION = 8'h00;
    localparam logic [7:0] OP_RESET_ARM    = 8'h66;
    localparam logic [7:0] OP_RESET        = 8'h99;
    localparam logic [7:0] OP_UNIQUE_ID    = 8'h4b;
    localparam logic [7:0] OP_PARAM_TABLE  = 8'h5a;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9f;

    // --------------------------------------------------------------
    // Framing
    // --------------------------------------------------------------
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [1:0] ADDR_BYTE_LAST  = 2'h2;
    localparam logic [1:0] UID_DUMMY_LAST  = 2'h3;
    localparam logic [1:0] PAR_DUMMY_LAST  = 2'h0;
    localparam logic [8:0] HDR_SHORT       = 9'h001;
    localparam logic [8:0] HDR_LONG        = 9'h005;
    localparam int         UID_BITS        = 128;
    localparam int         IDLE_IO         = 3;

    // Value arbitrary, stands in for a factory identifier
    localparam logic [UID_BITS-1:0] UID_DEFAULT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    // Value arbitrary, stands in for a maker code
    localparam logic [7:0] MAKER_DEFAULT   = 8'h3c;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int         CLK_MHZ         = 125;
    localparam int         SCK_HALF_NS     = 80;
    localparam int         SCK_HALF_CYC    = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SCK_HALF_LAST   = 8'(SCK_HALF_CYC - 1);

    typedef enum logic [2:0] {
        FRU_OP_NOP,
        FRU_OP_ARM,
        FRU_OP_RESET,
        FRU_OP_UID,
        FRU_OP_PARAM
    } fru_op_e;

    // --------------------------------------------------------------
    // Discoverable-parameter header bytes
    // --------------------------------------------------------------
    function automatic logic [7:0] fru_param_byte(input logic [23:0] a, input logic [7:0] maker);
        logic [7:0] v;
        v = 8'hff;
        if (a[23:8] == 16'h0000)
        begin
            unique case (a[7:0])
                // (RULE_10) Signature bytes
                8'h00: v = 8'h53;
                8'h01: v = 8'h46;
                8'h02: v = 8'h44;
                8'h03: v = 8'h50;
                // (RULE_11) Revision and count
                8'h04: v = 8'h00;
                8'h05: v = 8'h01;
                8'h06: v = 8'h01;
                // (RULE_13) First header
                8'h08: v = 8'h00;
                8'h09: v = 8'h00;
                8'h0a: v = 8'h01;
                8'h0b: v = 8'h09;
                8'h0c: v = 8'h30;
                8'h0d: v = 8'h00;
                8'h0e: v = 8'h00;
                // (RULE_14) Second header
                8'h10: v = maker;
                8'h11: v = 8'h00;
                8'h12: v = 8'h01;
                8'h13: v = 8'h03;
                8'h14: v = 8'h60;
                8'h15: v = 8'h00;
                8'h16: v = 8'h00;
                // (RULE_12) Unused bytes and table bodies
                default: v = 8'hff;
            endcase
        end
        return v;
    endfunction
endpackage

// [pkg/fru_spi_if.sv]
// Serial link between the flash command end and its host controller.
// Assumes the host makes chip select and the serial clock.
`timescale 1ns/10ps
interface fru_spi_if;
    logic       cs_n;
    logic       sclk;
    logic       si;
    logic [2:0] upper_io_lines;
    logic       so;
    logic       so_oe;

    modport dev
    (
        input  cs_n,
        input  sclk,
        input  si,
        input  upper_io_lines,
        output so,
        output so_oe
    );
    modport host
    (
        output cs_n,
        output sclk,
        output si,
        output upper_io_lines,
        input  so,
        input  so_oe
    );
endinterface

// [logic/fru_device.sv]
// Flash-side command interpreter: reset pair, no-operation, unique id and
// parameter-header reads. Link pins are asynchronous and are synchronised here;
// busy and suspend come from the array controller on the same clock.
`timescale 1ns/10ps
module fru_device
#(
    parameter logic [fru_pkg::UID_BITS-1:0] UNIQUE_ID = fru_pkg::UID_DEFAULT,
    parameter logic [7:0]                   MAKER_ID  = fru_pkg::MAKER_DEFAULT
)
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Link
    fru_spi_if.dev    link,
    // Array controller
    input  wire logic pe_busy_i,
    input  wire logic pe_suspended_i,
    output logic      soft_reset_o,
    output logic      pe_abort_o,
    output logic      reset_armed_o
);
    import fru_pkg::*;

    typedef enum logic [2:0] {
        DST_CMD,
        DST_ADDR,
        DST_DUMMY,
        DST_OUT,
        DST_IDLE
    } fru_dev_state_e;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] si_sync;
    logic       sclk_d;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cs_sync   <= 2'h3;
            sclk_sync <= 2'h0;
            si_sync   <= 2'h0;
            sclk_d    <= 1'b0;
        end
        else
        begin
            cs_sync   <= {cs_sync[0], link.cs_n};
            sclk_sync <= {sclk_sync[0], link.sclk};
            si_sync   <= {si_sync[0], link.si};
            sclk_d    <= sclk_sync[1];
        end
    end

    // --------------------------------------------------------------
    // Decode helpers
    // --------------------------------------------------------------
    fru_dev_state_e st;
    logic [7:0]     in_sr;
    logic [2:0]     bitc;
    logic [1:0]     bytec;
    logic [23:0]    addr;
    logic           is_param;
    logic [7:0]     obyte;
    logic [2:0]     obit;
    logic           rst_pend;

    logic           cs_high;
    logic           sclk_rise;
    logic           sclk_fall;
    logic [7:0]     next_in;
    logic           byte_done;
    logic           cmd_done;
    logic           go_out;
    logic           blocked;
    logic           abort_frame;

    // (RULE_06) Fixed read-only id
    function automatic logic [7:0] uid_byte(input logic [3:0] idx);
        logic [UID_BITS-1:0] t;
        t = UNIQUE_ID << {idx, 3'h0};
        return t[UID_BITS-1 -: 8];
    endfunction

    function automatic logic [7:0] out_byte(input logic p, input logic [23:0] a);
        return p ? fru_param_byte(a, MAKER_ID) : uid_byte(a[3:0]);
    endfunction

    always_comb
    begin
        cs_high   = cs_sync[1];
        sclk_rise = !cs_high && sclk_sync[1] && !sclk_d;
        sclk_fall = !cs_high && !sclk_sync[1] && sclk_d;
        // (RULE_02) Only the primary input is shifted
        next_in   = {in_sr[6:0], si_sync[1]};
        byte_done = sclk_rise && (bitc == BIT_LAST);
        cmd_done  = byte_done && (st == DST_CMD);
        go_out    = byte_done && (st == DST_DUMMY)
                    && (bytec == (is_param ? PAR_DUMMY_LAST : UID_DUMMY_LAST));
        // (RULE_15) Reads refused while the array works
        blocked   = pe_busy_i && !pe_suspended_i;
        abort_frame = cs_high && rst_pend;
    end

    // --------------------------------------------------------------
    // Command framing
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st       <= DST_CMD;
            in_sr    <= 8'h00;
            bitc     <= 3'h0;
            bytec    <= 2'h0;
            addr     <= 24'h000000;
            is_param <= 1'b0;
        end
        else if (cs_high)
        begin
            // (RULE_18) Chip select rise returns to command wait
            st    <= DST_CMD;
            bitc  <= 3'h0;
            bytec <= 2'h0;
        end
        else if (sclk_rise)
        begin
            in_sr <= next_in;
            bitc  <= bitc + 3'h1;
            if (byte_done)
            begin
                unique case (st)
                    DST_CMD:
                    begin
                        st    <= DST_IDLE;
                        bytec <= 2'h0;
                        addr  <= 24'h000000;
                        // (RULE_07) Unique id after four dummies
                        if (next_in == OP_UNIQUE_ID && !blocked)
                        begin
                            is_param <= 1'b0;
                            st       <= DST_DUMMY;
                        end
                        // (RULE_08) Table read takes address first
                        if (next_in == OP_PARAM_TABLE && !blocked)
                        begin
                            is_param <= 1'b1;
                            st       <= DST_ADDR;
                        end
                    end
                    DST_ADDR:
                    begin
                        addr  <= {addr[15:0], next_in};
                        bytec <= bytec + 2'h1;
                        if (bytec == ADDR_BYTE_LAST)
                        begin
                            bytec <= 2'h0;
                            st    <= DST_DUMMY;
                        end
                    end
                    DST_DUMMY:
                    begin
                        bytec <= bytec + 2'h1;
                        if (go_out)
                        begin
                            st <= DST_OUT;
                        end
                    end
                    DST_OUT,
                    DST_IDLE:
                    begin
                        st <= st;
                    end
                endcase
            end
        end
        else if (sclk_fall && st == DST_OUT && obit == 3'h0)
        begin
            // (RULE_17) Address steps after each byte
            addr <= addr + 24'h000001;
        end
    end

    // --------------------------------------------------------------
    // Serial output
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            link.so    <= 1'b0;
            link.so_oe <= 1'b0;
            obyte      <= 8'h00;
            obit       <= BIT_LAST;
        end
        else if (cs_high)
        begin
            // (RULE_09) Release the output when the frame ends
            link.so    <= 1'b0;
            link.so_oe <= 1'b0;
            obit       <= BIT_LAST;
        end
        else if (go_out)
        begin
            obyte      <= out_byte(is_param, addr);
            obit       <= BIT_LAST;
            link.so_oe <= 1'b1;
        end
        else if (sclk_fall && st == DST_OUT)
        begin
            // (RULE_17) Most significant bit first
            link.so <= obyte[obit];
            obit    <= obit - 3'h1;
            if (obit == 3'h0)
            begin
                obyte <= out_byte(is_param, addr + 24'h000001);
            end
        end
    end

    // --------------------------------------------------------------
    // Software reset pair
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            reset_armed_o <= 1'b0;
            rst_pend      <= 1'b0;
            soft_reset_o  <= 1'b0;
            pe_abort_o    <= 1'b0;
        end
        else
        begin
            soft_reset_o <= 1'b0;
            pe_abort_o   <= 1'b0;
            if (abort_frame)
            begin
                // (RULE_03) Pulse volatile-state reset to defaults
                soft_reset_o  <= 1'b1;
                // (RULE_05) Running program or erase is aborted
                pe_abort_o    <= pe_busy_i;
                rst_pend      <= 1'b0;
                reset_armed_o <= 1'b0;
            end
            else if (cmd_done)
            begin
                // (RULE_16) Reset pair never blocked by busy
                // (RULE_04) Any other command drops the arm
                reset_armed_o <= (next_in == OP_RESET_ARM);
                // (RULE_01) No-operation just clears the arm
                // (RULE_18) Unarmed reset is ignored
                rst_pend      <= (next_in == OP_RESET) && reset_armed_o;
            end
        end
    end
endmodule

// [logic/fru_host.sv]
// Host controller end: frames commands on the link and buffers read bytes.
// Assumes requests come from logic on the same clock.
`timescale 1ns/10ps
module fru_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    always_comb
    begin
        in_ready_o  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
        out_valid_o = (wr_ptr != rd_ptr);
        out_data_o  = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge clk_i)
    begin
        if (in_valid_i && in_ready_o)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (in_valid_i && in_ready_o)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_valid_o && out_ready_i)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module fru_host
(
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           reset_n_i,
    // Link
    fru_spi_if.host             link,
    // Requests
    input  wire logic           req_valid_i,
    input  wire fru_pkg::fru_op_e req_op_i,
    input  wire logic [23:0]    req_addr_i,
    input  wire logic [7:0]     req_len_i,
    output logic                req_ready_o,
    // Read data
    output logic                rd_valid_o,
    input  wire logic           rd_ready_i,
    output logic [7:0]          rd_data_o
);
    import fru_pkg::*;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_SETUP,
        HST_LOW,
        HST_HIGH,
        HST_WAIT,
        HST_GAP
    } fru_host_state_e;

    fru_host_state_e st;
    fru_op_e         op;
    logic [23:0]     addr;
    logic [8:0]      total;
    logic [8:0]      hdr_n;
    logic [8:0]      idx;
    logic [7:0]      txb;
    logic [7:0]      rx;
    logic [2:0]      bitn;
    logic [7:0]      div;
    logic            tick;
    logic [1:0]      so_sync;
    logic            push;
    logic            fifo_ready;

    function automatic logic [7:0] tx_byte(input fru_op_e o, input logic [23:0] a,
                                           input logic [8:0] i);
        logic [7:0] v;
        v = 8'h00;
        if (i == 9'h000)
        begin
            unique case (o)
                FRU_OP_NOP:   v = OP_NO_OPERATION;
                FRU_OP_ARM:   v = OP_RESET_ARM;
                FRU_OP_RESET: v = OP_RESET;
                FRU_OP_UID:   v = OP_UNIQUE_ID;
                FRU_OP_PARAM: v = OP_PARAM_TABLE;
            endcase
        end
        // (RULE_08) Three address bytes, high first
        else if (o == FRU_OP_PARAM && i < 9'h004)
        begin
            v = a[8'(31 - 8 * i) -: 8];
        end
        return v;
    endfunction

    fru_fifo
    #(
        .WIDTH (8),
        .DEPTH (16)
    )
    u_fifo
    (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (rx),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    // --------------------------------------------------------------
    // Clock divider and input synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div     <= 8'h00;
            tick    <= 1'b0;
            so_sync <= 2'h0;
        end
        else
        begin
            so_sync <= {so_sync[0], link.so};
            tick    <= (div == SCK_HALF_LAST);
            div     <= (div == SCK_HALF_LAST) ? 8'h00 : div + 8'h01;
        end
    end

    // --------------------------------------------------------------
    // Frame sequencer
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st                  <= HST_IDLE;
            op                  <= FRU_OP_NOP;
            addr                <= 24'h000000;
            total               <= 9'h000;
            hdr_n               <= 9'h000;
            idx                 <= 9'h000;
            txb                 <= 8'h00;
            rx                  <= 8'h00;
            bitn                <= BIT_LAST;
            push                <= 1'b0;
            req_ready_o         <= 1'b1;
            link.cs_n           <= 1'b1;
            link.sclk           <= 1'b0;
            link.si             <= 1'b0;
            link.upper_io_lines <= 3'h7;
        end
        else
        begin
            push <= 1'b0;
            unique case (st)
                HST_IDLE:
                begin
                    if (req_valid_i)
                    begin
                        op          <= req_op_i;
                        addr        <= req_addr_i;
                        hdr_n       <= (req_op_i inside {FRU_OP_UID, FRU_OP_PARAM})
                                       ? HDR_LONG : HDR_SHORT;
                        total       <= ((req_op_i inside {FRU_OP_UID, FRU_OP_PARAM})
                                       ? HDR_LONG : HDR_SHORT) + {1'b0, req_len_i};
                        idx         <= 9'h000;
                        txb         <= tx_byte(req_op_i, req_addr_i, 9'h000);
                        link.si     <= 1'(tx_byte(req_op_i, req_addr_i, 9'h000) >> BIT_LAST);
                        bitn        <= BIT_LAST;
                        link.cs_n   <= 1'b0;
                        req_ready_o <= 1'b0;
                        st          <= HST_SETUP;
                    end
                end
                HST_SETUP:
                begin
                    st <= tick ? HST_LOW : HST_SETUP;
                end
                HST_LOW:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        rx        <= {rx[6:0], so_sync[1]};
                        st        <= HST_HIGH;
                    end
                end
                HST_HIGH:
                begin
                    if (tick)
                    begin
                        link.sclk <= 1'b0;
                        if (bitn != 3'h0)
                        begin
                            bitn    <= bitn - 3'h1;
                            link.si <= txb[bitn-3'h1];
                            st      <= HST_LOW;
                        end
                        else
                        begin
                            push <= (idx >= hdr_n);
                            idx  <= idx + 9'h001;
                            // Stall at a byte edge so a full buffer never loses data
                            st   <= (idx + 9'h001 == total) ? HST_GAP : HST_WAIT;
                        end
                    end
                end
                HST_WAIT:
                begin
                    if (idx < hdr_n || (fifo_ready && !push))
                    begin
                        txb     <= tx_byte(op, addr, idx);
                        link.si <= 1'(tx_byte(op, addr, idx) >> BIT_LAST);
                        bitn    <= BIT_LAST;
                        st      <= HST_LOW;
                    end
                end
                HST_GAP:
                begin
                    link.cs_n <= 1'b1;
                    if (tick && link.cs_n)
                    begin
                        req_ready_o <= 1'b1;
                        st          <= HST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [bench/fru_assertions.sv]
// Wire-level checks on the link between the command end and its host.
// Assumes both ends share clk_i and reset_n_i.
`timescale 1ns/10ps
module fru_assertions
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Link
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       si,
    input  wire logic [2:0] upper_io_lines,
    input  wire logic       so,
    input  wire logic       so_oe
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // --------------------------------------------------------------
    // Link framing
    // --------------------------------------------------------------
    a_upper_held: assert property (upper_io_lines == 3'h7)
        else $error("upper lines moved");
    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("clock high outside frame");
    a_si_hold: assert property (sclk && $past(sclk) |-> $stable(si))
        else $error("serial in moved while clock high");
    a_so_hold: assert property (so_oe && sclk && $past(sclk) |-> $stable(so))
        else $error("serial out moved while clock high");
    a_sclk_half: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*2] ##1 !sclk)
        else $error("clock high phase not ten cycles");
    a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*8])
        else $error("chip select gap too short");
    a_oe_release: assert property (cs_n[*5] |-> !so_oe)
        else $error("output still driven after deselect");
    a_oe_quiet: assert property ($fell(cs_n) |-> (!so_oe)[*8])
        else $error("output driven during opcode");
    cover property ($rose(so_oe));
    cover property (so_oe && $rose(cs_n));
    cover property ($rose(cs_n) ##[1:20] $fell(cs_n));
endmodule

// [bench/test_flash_reset_uid_sfdp_cmds.sv]
// Bench joining host and command end over one link.
// Assumes host requests drive all framing; inputs change at falling edges.
`timescale 1ns/10ps
`define CK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %0t %h %h", $time, (a), (e)); end end
module test_flash_reset_uid_sfdp_cmds;
    import fru_pkg::*;
    logic       clk_i = 1'b0, reset_n_i = 1'b0, pe_busy_i = 1'b0, pe_suspended_i = 1'b0;
    logic       req_valid_i = 1'b0, rd_ready_i = 1'b0;
    fru_op_e    req_op_i = FRU_OP_NOP;
    logic [23:0] req_addr_i = 24'h000000;
    logic [7:0] req_len_i = 8'h00, rd_data_o;
    logic       soft_reset_o, pe_abort_o, reset_armed_o, req_ready_o, rd_valid_o;
    int         num_errors = 0, tests_run = 0, n_rst = 0, n_abt = 0, r0, a0, k, j;
    int         ea [4] = '{5, 14, 22, 23};
    logic [7:0] hdr [26] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff, MAKER_DEFAULT, 8'h00,
        8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
    fru_spi_if link ();
    fru_device u_fru_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
        .pe_busy_i(pe_busy_i), .pe_suspended_i(pe_suspended_i),
        .soft_reset_o(soft_reset_o), .pe_abort_o(pe_abort_o), .reset_armed_o(reset_armed_o));
    fru_host u_fru_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
        .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
        .req_len_i(req_len_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o));
    fru_assertions u_fru_assertions (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n(link.cs_n),
        .sclk(link.sclk), .si(link.si), .upper_io_lines(link.upper_io_lines),
        .so(link.so), .so_oe(link.so_oe));
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (soft_reset_o === 1'b1) n_rst++;
        if (pe_abort_o === 1'b1) n_abt++;
    end
    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic idle;
        for (int i = 0; i < 20000 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
    endtask
    task automatic send(input fru_op_e op, input logic [23:0] a, input logic [7:0] n);
        idle();
        req_op_i = op;
        req_addr_i = a;
        req_len_i = n;
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic pop(input logic [7:0] e);
        for (int i = 0; i < 20000 && rd_valid_o !== 1'b1; i++) @(negedge clk_i);
        `CK(rd_data_o, e)
        rd_ready_i = 1'b1;
        @(negedge clk_i);
        rd_ready_i = 1'b0;
    endtask
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        send(FRU_OP_PARAM, 24'h000000, 8'd24);
        // Let the buffer fill so the host stalls
        repeat (6000) @(negedge clk_i);
        for (k = 0; k < 24; k++) pop(hdr[k]);
        for (k = 0; k < 4; k++)
        begin
            send(FRU_OP_PARAM, 24'(ea[k]), 8'd2);
            for (j = 0; j < 2; j++) pop(hdr[ea[k] + j]);
        end
        for (k = 0; k < 5; k++)
        begin
            pe_busy_i = k > 2;
            pe_suspended_i = k == 4;
            r0 = n_rst;
            a0 = n_abt;
            send(FRU_OP_ARM, 24'h000000, 8'd0);
            idle();
            `CK(reset_armed_o, 1'b1)
            if (k == 1) send(FRU_OP_NOP, 24'h000000, 8'd0);
            if (k == 2) send(FRU_OP_UID, 24'h000000, 8'd0);
            idle();
            `CK(reset_armed_o, 1'(k == 0 || k > 2))
            send(FRU_OP_RESET, 24'h000000, 8'd0);
            idle();
            `CK(n_rst - r0, (k == 1 || k == 2) ? 0 : 1)
            `CK(n_abt - a0, (k > 2) ? 1 : 0)
            `CK(reset_armed_o, 1'b0)
        end
        pe_suspended_i = 1'b0;
        send(FRU_OP_UID, 24'h000000, 8'd1);
        pop(8'h00);
        pe_busy_i = 1'b0;
        send(FRU_OP_UID, 24'h000000, 8'd16);
        for (k = 0; k < 16; k++) pop(UID_DEFAULT[127 - 8 * k -: 8]);
        idle();
        wrap_up();
    end
    initial
    begin
        #600000;
        num_errors++;
        wrap_up();
    end
endmodule
